/* File: logic/fault_restart_pkg.sv */
// Purpose: Constants and types for the fault restart supervisor.
// Assumes: 40 MHz system clock, AXI4-Lite register access.
// Notes: Overview of operation follows.
package fault_restart_pkg;
   // ----------------------------------------
   // Fault categories and classes
   // ----------------------------------------
   localparam int NUM_FAULTS = 14;
   // Bit set means delayed restart allowed; index order matches the fault inputs.
   localparam logic [13:0] RESTART_CLASS_MASK = 14'h0DFC;
   localparam logic [4:0] CODE_NONE = 5'h00;
   // ----------------------------------------
   // Timing and limits
   // ----------------------------------------
   localparam int CLOCK_HZ = 40000000;
   localparam int RESTART_DELAY_S = 60;
   localparam int MAX_RESTARTS = 10;
   localparam int USER_COUNT_MAX = 10;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
   localparam logic [7:0] ADDR_COUNT_LO = 8'h10;
   localparam logic [7:0] ADDR_COUNT_HI = 8'h14;
   localparam int CTRL_NO_RESTART_BIT = 0;
   localparam int CTRL_LOG_VIEW_BIT = 1;
   localparam int INT_FAULT_BIT = 0;
   localparam int INT_RESTART_BIT = 1;
   localparam int INT_LOCKOUT_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {ST_RUN, ST_COUNTDOWN, ST_LATCHED} sup_state_type;
   typedef struct packed {
      logic prompt;
      logic [4:0] code;
      logic [5:0] seconds;
   } display_type;
endpackage : fault_restart_pkg

/* File: logic/fault_restart_supervisor.sv */
// Purpose: Sorts converter faults, runs the restart countdown and gates the output.
// Assumes: Fault inputs are synchronous levels; a fault is taken on its rising edge.
// Notes: Power-on reset is the power-cycle clear for every latched condition.
module fault_restart_supervisor
#(
   parameter int CYCLES_PER_SECOND = fault_restart_pkg::CLOCK_HZ
)
(
   // Clock, reset, enable
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Converter side
   input wire logic [13:0] fault_in,
   output logic output_enable_out,
   output fault_restart_pkg::display_type display_out,
   output logic irq_out,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import fault_restart_pkg::*;

   if (CYCLES_PER_SECOND < 1)
   begin : g_check
      $error("CYCLES_PER_SECOND must be at least one");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   sup_state_type state_q;
   logic [13:0] fault_prev_q, rise, sel, at_max;
   logic [31:0] tick_q;
   logic [5:0] seconds_q;
   logic [3:0] restarts_q;
   logic [4:0] code_q, sel_code;
   logic prompt_q, no_restart_q, log_view_q;
   logic [2:0] int_status_q, int_mask_q;
   logic [55:0] counts;
   logic fault_ev, sel_restartable, sel_saturated, sec_tick, ev_restart, ev_lockout;

   // ----------------------------------------
   // Fault selection
   // ----------------------------------------
   assign rise = fault_in & ~fault_prev_q;
   assign fault_ev = |rise;

   // Lowest index wins when faults rise together; only one category is counted per cycle.
   always_comb
   begin
      sel = 14'h0000;
      sel_code = CODE_NONE;
      for (int i = NUM_FAULTS - 1; i >= 0; i--)
      begin
         if (rise[i])
         begin
            sel = 14'h0000;
            sel[i] = 1'b1;
            sel_code = 5'(i + 1);
         end
      end
   end

   assign sel_restartable = |(sel & RESTART_CLASS_MASK);

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         fault_prev_q <= 14'h0000;
      else if (ce_in)
         fault_prev_q <= fault_in;
   end

   // ----------------------------------------
   // Per-category user counts
   // ----------------------------------------
   for (genvar g = 0; g < NUM_FAULTS; g++)
   begin : g_count
      logic [3:0] cnt_q;
      // Reset clears every count, including the one that caused the lockout.
      always_ff @(posedge clock_in or negedge rstn_in)
      begin
         if (!rstn_in)
            cnt_q <= 4'h0;
         else if (ce_in && fault_ev && sel[g] && cnt_q != 4'(USER_COUNT_MAX))
            cnt_q <= cnt_q + 4'h1;
      end
      assign counts[g * 4 +: 4] = cnt_q;
      assign at_max[g] = (cnt_q == 4'(USER_COUNT_MAX));
   end
   assign sel_saturated = |(sel & at_max);

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         prompt_q <= 1'b0;
      else if (ce_in && fault_ev && sel_saturated)
         prompt_q <= 1'b1;
   end

   // ----------------------------------------
   // Supervisor sequence
   // ----------------------------------------
   assign sec_tick = (tick_q == 32'(CYCLES_PER_SECOND - 1));
   assign ev_restart = (state_q == ST_COUNTDOWN) && sec_tick && seconds_q == 6'h01 && !fault_ev;
   assign ev_lockout = fault_ev && !(sel_restartable && !no_restart_q && restarts_q != 4'(MAX_RESTARTS)
                       && state_q == ST_RUN) && state_q != ST_LATCHED;

   // Reset drops straight into run with nothing pending, as after a normal power-up.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_q <= ST_RUN;
         restarts_q <= 4'h0;
         seconds_q <= 6'h00;
         code_q <= CODE_NONE;
      end
      else if (ce_in)
      begin
         case (state_q)
            ST_RUN:
            begin
               if (fault_ev)
               begin
                  code_q <= sel_code;
                  if (sel_restartable && !no_restart_q && restarts_q != 4'(MAX_RESTARTS))
                  begin
                     state_q <= ST_COUNTDOWN;
                     seconds_q <= 6'(RESTART_DELAY_S);
                     restarts_q <= restarts_q + 4'h1;
                  end
                  else
                     state_q <= ST_LATCHED;
               end
            end
            ST_COUNTDOWN:
            begin
               // A fault of either class during the delay ends it in a latch.
               if (fault_ev)
               begin
                  code_q <= sel_code;
                  state_q <= ST_LATCHED;
                  seconds_q <= 6'h00;
               end
               else if (sec_tick)
               begin
                  seconds_q <= seconds_q - 6'h01;
                  if (seconds_q == 6'h01)
                  begin
                     state_q <= ST_RUN;
                     code_q <= CODE_NONE;
                  end
               end
            end
            ST_LATCHED: state_q <= ST_LATCHED;
            default: state_q <= ST_LATCHED;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         tick_q <= 32'h00000000;
      else if (ce_in)
      begin
         if (state_q != ST_COUNTDOWN || sec_tick)
            tick_q <= 32'h00000000;
         else
            tick_q <= tick_q + 32'h00000001;
      end
   end

   // ----------------------------------------
   // Outputs to the converter and display
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         output_enable_out <= 1'b0;
         display_out <= '0;
      end
      else if (ce_in)
      begin
         // Cleared on the same edge that takes the state out of run, so a fault edge never leaves it on one extra cycle.
         output_enable_out <= (state_q == ST_RUN) && !fault_ev && !log_view_q;
         display_out.code <= code_q;
         display_out.seconds <= seconds_q;
         display_out.prompt <= prompt_q;
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_held_q, w_held_q, wstrb0_q, do_write;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rd_word;
   logic [2:0] int_clear, int_set;

   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   assign int_clear = (do_write && awaddr_q == ADDR_INT_STATUS && wstrb0_q) ? wdata_q[2:0] : 3'h0;
   assign int_set = {ev_lockout, ev_restart, fault_ev};

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb0_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (ce_in)
      begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q <= ADDR_COUNT_HI && awaddr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         no_restart_q <= 1'b0;
         log_view_q <= 1'b0;
         int_mask_q <= 3'h0;
      end
      else if (ce_in && do_write && wstrb0_q)
      begin
         if (awaddr_q == ADDR_CTRL)
         begin
            no_restart_q <= wdata_q[CTRL_NO_RESTART_BIT];
            log_view_q <= wdata_q[CTRL_LOG_VIEW_BIT];
         end
         if (awaddr_q == ADDR_INT_MASK)
            int_mask_q <= wdata_q[2:0];
      end
   end

   // A new event in the clearing cycle keeps its bit set.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         int_status_q <= 3'h0;
         irq_out <= 1'b0;
      end
      else if (ce_in)
      begin
         int_status_q <= (int_status_q & ~int_clear) | int_set;
         irq_out <= |(((int_status_q & ~int_clear) | int_set) & int_mask_q);
      end
   end

   always_comb
   begin
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         ADDR_CTRL: rd_word = {30'h00000000, log_view_q, no_restart_q};
         ADDR_STATUS: rd_word = {prompt_q, 3'h0, restarts_q, 2'h0, seconds_q, 3'h0, code_q, 6'h00, state_q};
         ADDR_INT_STATUS: rd_word = {29'h00000000, int_status_q};
         ADDR_INT_MASK: rd_word = {29'h00000000, int_mask_q};
         ADDR_COUNT_LO: rd_word = counts[31:0];
         ADDR_COUNT_HI: rd_word = {8'h00, counts[55:32]};
         default: rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (ce_in)
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr <= ADDR_COUNT_HI && s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule : fault_restart_supervisor

/* File: sim/fault_restart_properties.sv */
// Purpose: Concurrent checks on the supervisor's converter-side ports.
// Assumes: ce_in is held high by the bench.
// Notes: Bound into the supervisor after the module.
module fault_restart_properties import fault_restart_pkg::*;
#(
   parameter int CYCLES_PER_SECOND = CLOCK_HZ
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Watched ports
   input wire logic [13:0] fault_in,
   input wire logic output_enable_out,
   input wire fault_restart_pkg::display_type display_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Indices 2 to 8, 10 and 11 may restart; all others latch.
   localparam logic [13:0] CLASS2 = 14'h0DFC;
   logic [13:0] fin_q;
   logic [13:0] rise;
   logic [5:0] sec_q;
   int hold_q;
   assign rise = fault_in & ~fin_q;
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         fin_q <= 14'h0000;
         sec_q <= 6'h00;
         hold_q <= 0;
      end
      else
      begin
         fin_q <= fault_in;
         sec_q <= display_out.seconds;
         hold_q <= (display_out.seconds != sec_q) ? 1 : hold_q + 1;
      end
   end
   function automatic logic [4:0] first_code(input logic [13:0] v);
      first_code = 5'h00;
      for (int i = 13; i >= 0; i--)
         if (v[i])
            first_code = 5'(i + 1);
   endfunction : first_code
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_take;
      output_enable_out && (rise != 14'h0000);
   endsequence
   sequence s_dark8;
      !output_enable_out [*8];
   endsequence
   // The first and last second of a countdown are skipped, though the tick count starts from zero and gives them the same length.
   sequence s_tick;
      display_out.seconds != sec_q && sec_q != 6'h00 && sec_q != 6'h3C && display_out.seconds != 6'h00;
   endsequence
   property p_fault_off;
      s_take |=> !output_enable_out;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("output stayed on after a fault");
   property p_code;
      s_take |-> ##2 display_out.code == first_code($past(rise, 2));
   endproperty
   a_code: assert property (p_code) else $error("wrong fault code shown");
   property p_latch_hold;
      s_take ##0 ((rise & CLASS2) == 14'h0000) |=> s_dark8;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latching fault released");
   property p_dec;
      s_tick |-> display_out.seconds == $past(display_out.seconds) - 6'h01;
   endproperty
   a_dec: assert property (p_dec) else $error("countdown skipped a second");
   property p_second;
      s_tick |-> hold_q == CYCLES_PER_SECOND;
   endproperty
   a_second: assert property (p_second) else $error("second has wrong length");
   // A fault in the last second latches instead of restarting, so that case is left out.
   property p_restart;
      $past(display_out.seconds) == 6'h01 && display_out.seconds == 6'h00 && $past(rise, 2) == 14'h0000
         |-> ##[0:2] output_enable_out;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart at end of countdown");
   property p_prompt;
      display_out.prompt |=> display_out.prompt;
   endproperty
   a_prompt: assert property (p_prompt) else $error("power cycle prompt dropped");
   property p_quiet;
      output_enable_out && $past(output_enable_out) |-> display_out.code == 5'h00 && display_out.seconds == 6'h00;
   endproperty
   a_quiet: assert property (p_quiet) else $error("fault shown while running");
   property p_reset_run;
      $rose(rstn_in) |-> ##1 (output_enable_out && display_out.code == 5'h00);
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("no clean start after reset");
endmodule : fault_restart_properties
bind fault_restart_supervisor fault_restart_properties #(.CYCLES_PER_SECOND(CYCLES_PER_SECOND)) props (.*);

/* File: sim/fault_sensor_model.sv */
// Purpose: Converter fault sensors driving the supervisor's fault levels.
// Assumes: One fault pulse at a time.
// Notes: The level is held for three cycles; only its rising edge counts.
module fault_sensor_model import fault_restart_pkg::*;
(
   // Clock
   input wire logic clock_in,
   // Fault levels
   output logic [13:0] fault_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial fault_out = 14'h0000;
   task automatic pulse(input int idx);
      @(posedge clock_in);
      fault_out[idx] <= 1'h1;
      repeat (3) @(posedge clock_in);
      fault_out[idx] <= 1'h0;
   endtask : pulse
endmodule : fault_sensor_model

/* File: sim/fault_restart_supervisor_tb.sv */
// Purpose: Self-checking bench for the fault restart supervisor.
// Assumes: Four clocks stand for one second of countdown.
// Notes: Registers are reached through AXI4-Lite tasks.
module fault_restart_supervisor_tb import fault_restart_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPS = 4;
   localparam logic [13:0] CLASS2 = 14'h0DFC;
   logic clock_in = 1'h0;
   logic rstn_in = 1'h0;
   logic ce_in = 1'h1;
   logic [13:0] fault_in;
   logic output_enable_out, irq_out;
   display_type display_out;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int error_cnt = 0;
   int total_checks = 0;
   int n;
   fault_restart_supervisor #(.CYCLES_PER_SECOND(CPS)) dut (.*);
   fault_sensor_model sens (.clock_in(clock_in), .fault_out(fault_in));
   always #12.5 clock_in = ~clock_in;
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_in);
   endtask : cyc
   task automatic por();
      @(posedge clock_in);
      rstn_in <= 1'h0;
      cyc(10);
      rstn_in <= 1'h1;
      cyc(2);
   endtask : por
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge clock_in);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", {1'h1, er}, {s_axi_bvalid, s_axi_bresp});
   endtask : axw
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge clock_in);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rresp", {1'h1, er}, {s_axi_rvalid, s_axi_rresp});
      chk("rdata", e, s_axi_rdata & m);
   endtask : rchk
   task automatic wait_on(input int lim);
      n = 0;
      while (output_enable_out !== 1'h1 && n < lim)
      begin
         @(posedge clock_in);
         n++;
      end
   endtask : wait_on
   task automatic end_sim();
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial
   begin
      #1ms;
      error_cnt++;
      end_sim();
   end
   initial
   begin
      por();
      chk("enable", 32'h1, output_enable_out);
      rchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
      rchk(8'h18, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      for (int i = 0; i < 14; i++)
      begin
         por();
         sens.pulse(i);
         cyc(1);
         chk("enable", 32'h0, output_enable_out);
         chk("code", i + 1, display_out.code);
         chk("seconds", CLASS2[i] ? 32'h3C : 32'h0, display_out.seconds);
      end
      por();
      sens.pulse(2);
      chk("seconds", 32'h3C, display_out.seconds);
      por();
      chk("enable", {1'h1, 12'h000}, {output_enable_out, display_out});
      axw(ADDR_INT_MASK, 32'h7, RESP_OKAY);
      for (int k = 0; k < 11; k++)
      begin
         sens.pulse(k % 9 < 7 ? k % 9 + 2 : k % 9 + 3);
         wait_on(300);
         chk("restart", k < 10, output_enable_out);
         if (k == 0)
            chk("delay", 32'h1, n >= 60 * CPS - 8 && n <= 60 * CPS + 4);
      end
      chk("code", 32'h4, display_out.code);
      rchk(ADDR_STATUS, 32'h0F000003, 32'h0A000002, RESP_OKAY);
      rchk(ADDR_INT_STATUS, 32'h7, 32'h7, RESP_OKAY);
      axw(ADDR_INT_MASK, 32'h0, RESP_OKAY);
      cyc(1);
      chk("irq", 32'h0, irq_out);
      axw(ADDR_INT_MASK, 32'h7, RESP_OKAY);
      cyc(1);
      chk("irq", 32'h1, irq_out);
      axw(ADDR_INT_STATUS, 32'h7, RESP_OKAY);
      rchk(ADDR_INT_STATUS, 32'h7, 32'h0, RESP_OKAY);
      chk("irq", 32'h0, irq_out);
      por();
      for (int k = 0; k < 12; k++)
         sens.pulse(1);
      cyc(2);
      chk("prompt", 32'h1, display_out.prompt);
      chk("enable", 32'h0, output_enable_out);
      rchk(ADDR_COUNT_LO, 32'hF0, 32'hA0, RESP_OKAY);
      por();
      chk("prompt", 32'h0, display_out.prompt);
      rchk(ADDR_COUNT_LO, 32'hF0, 32'h0, RESP_OKAY);
      axw(ADDR_CTRL, 32'h1, RESP_OKAY);
      sens.pulse(3);
      wait_on(300);
      chk("no restart", 32'h0, {output_enable_out, display_out.seconds});
      por();
      axw(ADDR_CTRL, 32'h2, RESP_OKAY);
      cyc(2);
      chk("log view", 32'h0, output_enable_out);
      axw(ADDR_CTRL, 32'h0, RESP_OKAY);
      cyc(2);
      chk("log view", 32'h1, output_enable_out);
      end_sim();
   end
endmodule : fault_restart_supervisor_tb
